//--- hdl/ref_cfg_pkg.sv
// Purpose: constants and lookups for the reference input front end
// Assumes: 8-bit register port, 20 MHz system clock
// Notes:   frequencies are held in kHz
package ref_cfg_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    // arbitrary identification values, not tied to any product
    localparam logic [15:0] IDENT_CODE = 16'h5a3c;
    localparam logic [7:0] REVISION_VAL = 8'h01;
    // --------------------------------------------------------------
    // register map
    // --------------------------------------------------------------
    localparam logic [7:0] A_IDENT_LOW = 8'h00;
    localparam logic [7:0] A_IDENT_HIGH = 8'h01;
    localparam logic [7:0] A_REVISION = 8'h02;
    localparam logic [7:0] A_WRITE_GUARD = 8'h03;
    localparam logic [7:0] A_TRIM_LO = 8'h04;
    localparam logic [7:0] A_TRIM_HI = 8'h05;
    localparam logic [7:0] A_MASTER_CFG1 = 8'h06;
    localparam logic [7:0] A_MASTER_CFG3 = 8'h07;
    localparam logic [7:0] A_INPUT_CFG_A = 8'h08;
    localparam logic [7:0] A_INPUT_CFG_B = 8'h09;
    localparam logic [7:0] A_DIVIDER_LO = 8'h0a;
    localparam logic [7:0] A_DIVIDER_HI = 8'h0b;
    localparam logic [7:0] A_TEST_CFG1 = 8'h0c;
    localparam logic [7:0] A_VALID_LIVE = 8'h0d;
    localparam logic [7:0] A_VALID_LATCHED = 8'h0e;
    localparam logic [7:0] A_VALID_IRQ_EN = 8'h0f;
    localparam logic [7:0] A_SELECT_STAT = 8'h10;
    // fields and reset values
    localparam logic [7:0] GUARD_KEY = 8'h85;
    localparam int FREQ_MSB = 3;
    localparam int EIGHT_KHZ_LOCK_SEL_BIT = 4;
    localparam int DIVMODE_BIT = 5;
    localparam logic [15:0] TRIM_RST = 16'h997b;
    localparam logic [16:0] TRIM_ZERO = 17'h0997b;
    localparam logic [21:0] TRIM_MOD = 22'h309962;
    localparam logic [4:0] MASTER_PER_OSC = 5'h10;
    localparam logic [5:0] MON_LAST = 6'h3f;
    localparam logic [23:0] MEAS_SCALE = 24'hc80000;
    localparam logic [7:0] TOL_MUL = 8'h29;
    localparam int TOL_SHIFT = 12;
    localparam logic [16:0] KHZ_8K = 17'h00008;
    localparam logic [3:0] FC_4K = 4'h1;
    typedef enum logic [1:0] {
        LM_DIRECT = 2'b00,
        LM_EIGHT_K = 2'b01,
        LM_DIV_N = 2'b10,
        LM_ALT = 2'b11
    } lock_mode_t;

    // source frequency in kHz per frequency code
    function automatic logic [16:0] src_khz(input logic [3:0] c, input logic son,
                                            input logic alt);
        case (c)
            4'h0: src_khz = 17'h00002;
            4'h1: src_khz = 17'h00004;
            4'h2: src_khz = KHZ_8K;
            4'h3: src_khz = son ? 17'h00608 : 17'h00800;
            4'h4: src_khz = 17'h018a8;
            4'h5: src_khz = 17'h01950;
            4'h6: src_khz = 17'h04bf0;
            4'h7: src_khz = 17'h06540;
            4'h8: src_khz = 17'h097e0;
            4'h9: src_khz = 17'h0ca80;
            4'ha: src_khz = 17'h12fc0;
            4'hb: src_khz = alt ? 17'h02710 : 17'h01388;
            4'hc: src_khz = alt ? 17'h061a8 : 17'h07a12;
            4'hd: src_khz = alt ? 17'h0f424 : 17'h061a8;
            4'he: src_khz = alt ? 17'h1e848 : 17'h0f424;
            default: src_khz = KHZ_8K;
        endcase
    endfunction

    // internal division applied in alternate direct lock
    function automatic logic [15:0] alt_ratio(input logic [3:0] c);
        case (c)
            4'hb: alt_ratio = 16'h0002;
            4'hc: alt_ratio = 16'h0005;
            4'hd: alt_ratio = 16'h0002;
            4'he: alt_ratio = 16'h0004;
            default: alt_ratio = 16'h0001;
        endcase
    endfunction

    // strap pattern to frequency code, always direct lock
    function automatic logic [3:0] strap_code(input logic [2:0] s);
        case (s)
            3'h0: strap_code = 4'h2;
            3'h1: strap_code = 4'h3;
            3'h2: strap_code = 4'h5;
            3'h3: strap_code = 4'h6;
            3'h4: strap_code = 4'h7;
            3'h5: strap_code = 4'h8;
            3'h6: strap_code = 4'h9;
            default: strap_code = 4'ha;
        endcase
    endfunction
endpackage

//--- hdl/ref_input_config_monitor.sv
// Purpose: identification, write guard, master trim, input config and monitor
// Assumes: all pins synchronous to mclk_in; reference and oscillator edges
//          arrive slower than mclk_in/2
// Notes:   leaky bucket activity alarm comes in on activity_alarm_in
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - read-only 16-bit identity, plus revision register
// - guard register protects configuration registers
// - master timebase derived from local oscillator
// - master trim field, -771 to +514 ppm
// - sonet bit selects 1.544 versus 2.048 MHz
// - sonet bit default taken from strap
// - frequency straps set default, direct lock
// - frequency field per input config register
// - two bits select among four lock modes
// - direct lock compares at configured frequency
// - alternate lock divides to 31.25/5 MHz
// - eight kHz lock divides reference to 8kHz
// - test bit picks edge for 8kHz lock
// - 2k/4k inputs ignore 8kHz lock bit
// - divide-by-N uses shared value plus one
// - live valid, latched change, interrupt if enabled
// - invalid input never selected automatically
// - off by more than 10000ppm invalidates input
// - frequency measured against master timebase
// - activity alarm marks input invalid
module ref_input_config_monitor (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic [ref_cfg_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic [ref_cfg_pkg::DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [ref_cfg_pkg::DATA_W-1:0] reg_rdata_out,
    input wire logic local_osc_in,
    input wire logic ref_input_a_in,
    input wire logic ref_input_b_in,
    input wire logic sonet_sdh_sel_in,
    input wire logic [2:0] default_freq_straps_in,
    input wire logic [1:0] activity_alarm_in,
    output logic [1:0] input_valid_out,
    output logic valid_irq_out,
    output logic [1:0] lock_event_out,
    output logic selected_ref_out,
    output logic selected_ok_out,
    output logic [4:0] master_step_out
);
    import ref_cfg_pkg::*;

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    function automatic lock_mode_t eff_mode(input logic [5:0] cfg);
        lock_mode_t m;
        m = lock_mode_t'({cfg[DIVMODE_BIT], cfg[EIGHT_KHZ_LOCK_SEL_BIT]});
        if (m == LM_EIGHT_K && cfg[FREQ_MSB:0] <= FC_4K) begin
            m = LM_DIRECT;
        end
        return m;
    endfunction

    function automatic logic [16:0] cmp_khz(input logic [5:0] cfg, input logic son);
        logic [16:0] f;
        f = src_khz(cfg[FREQ_MSB:0], son, 1'b0);
        case (eff_mode(cfg))
            LM_EIGHT_K: f = KHZ_8K;
            LM_ALT: f = 17'(src_khz(cfg[FREQ_MSB:0], son, 1'b1)
                            / 17'(alt_ratio(cfg[FREQ_MSB:0])));
            default: f = src_khz(cfg[FREQ_MSB:0], son, 1'b0);
        endcase
        return f;
    endfunction

    function automatic logic [15:0] term_cnt(input logic [5:0] cfg, input logic son,
                                             input logic [15:0] ref_divider_value);
        logic [16:0] s;
        s = src_khz(cfg[FREQ_MSB:0], son, 1'b0);
        case (eff_mode(cfg))
            LM_EIGHT_K: term_cnt = 16'((s >> 3) - 17'h1);
            LM_DIV_N: term_cnt = ref_divider_value;
            LM_ALT: term_cnt = alt_ratio(cfg[FREQ_MSB:0]) - 16'h1;
            default: term_cnt = 16'h0000;
        endcase
    endfunction

    // --------------------------------------------------------------
    // register file
    // --------------------------------------------------------------
    logic [7:0] guard_ff, nxt_guard;
    logic [15:0] trim_ff, nxt_trim;
    logic mon_en_ff, nxt_mon_en;
    logic sonet_ff, nxt_sonet;
    logic [1:0][5:0] cfg_ff, nxt_cfg;
    logic [15:0] ref_divider_value_ff, nxt_ref_divider_value;
    logic edge_sel_ff, nxt_edge_sel;
    logic [1:0] latched_ff, nxt_latched;
    logic [1:0] irq_en_ff, nxt_irq_en;
    logic [7:0] nxt_rdata;
    logic irq_ff, nxt_irq;
    logic [1:0] valid_ff, nxt_valid;
    logic sel_ff, nxt_sel, sel_ok_ff, nxt_sel_ok;
    logic guard_open, cfg_wr;

    assign guard_open = (guard_ff == GUARD_KEY);
    assign cfg_wr = reg_wr_in && guard_open;

    always_comb begin
        nxt_guard = guard_ff;
        nxt_trim = trim_ff;
        nxt_mon_en = mon_en_ff;
        nxt_sonet = sonet_ff;
        nxt_cfg = cfg_ff;
        nxt_ref_divider_value = ref_divider_value_ff;
        nxt_edge_sel = edge_sel_ff;
        nxt_irq_en = irq_en_ff;
        nxt_latched = latched_ff;
        if (reg_wr_in && reg_addr_in == A_WRITE_GUARD) begin
            nxt_guard = reg_wdata_in;
        end
        if (reg_wr_in && reg_addr_in == A_VALID_LATCHED) begin
            nxt_latched = latched_ff & ~reg_wdata_in[1:0];
        end
        // a change in the same cycle as the clear still lands
        nxt_latched = nxt_latched | (nxt_valid ^ valid_ff);
        if (cfg_wr) begin
            case (reg_addr_in)
                A_TRIM_LO: nxt_trim[7:0] = reg_wdata_in;
                A_TRIM_HI: nxt_trim[15:8] = reg_wdata_in;
                A_MASTER_CFG1: nxt_mon_en = reg_wdata_in[0];
                A_MASTER_CFG3: nxt_sonet = reg_wdata_in[0];
                A_INPUT_CFG_A: nxt_cfg[0] = reg_wdata_in[5:0];
                A_INPUT_CFG_B: nxt_cfg[1] = reg_wdata_in[5:0];
                A_DIVIDER_LO: nxt_ref_divider_value[7:0] = reg_wdata_in;
                A_DIVIDER_HI: nxt_ref_divider_value[15:8] = reg_wdata_in;
                A_TEST_CFG1: nxt_edge_sel = reg_wdata_in[0];
                A_VALID_IRQ_EN: nxt_irq_en = reg_wdata_in[1:0];
                default: nxt_irq_en = irq_en_ff;
            endcase
        end
        nxt_irq = |(latched_ff & irq_en_ff);
        nxt_rdata = 8'h00;
        if (reg_rd_in) begin
            case (reg_addr_in)
                A_IDENT_LOW: nxt_rdata = IDENT_CODE[7:0];
                A_IDENT_HIGH: nxt_rdata = IDENT_CODE[15:8];
                A_REVISION: nxt_rdata = REVISION_VAL;
                A_WRITE_GUARD: nxt_rdata = guard_ff;
                A_TRIM_LO: nxt_rdata = trim_ff[7:0];
                A_TRIM_HI: nxt_rdata = trim_ff[15:8];
                A_MASTER_CFG1: nxt_rdata = {7'h00, mon_en_ff};
                A_MASTER_CFG3: nxt_rdata = {7'h00, sonet_ff};
                A_INPUT_CFG_A: nxt_rdata = {2'b00, cfg_ff[0]};
                A_INPUT_CFG_B: nxt_rdata = {2'b00, cfg_ff[1]};
                A_DIVIDER_LO: nxt_rdata = ref_divider_value_ff[7:0];
                A_DIVIDER_HI: nxt_rdata = ref_divider_value_ff[15:8];
                A_TEST_CFG1: nxt_rdata = {7'h00, edge_sel_ff};
                A_VALID_LIVE: nxt_rdata = {6'h00, valid_ff};
                A_VALID_LATCHED: nxt_rdata = {6'h00, latched_ff};
                A_VALID_IRQ_EN: nxt_rdata = {6'h00, irq_en_ff};
                A_SELECT_STAT: nxt_rdata = {6'h00, sel_ok_ff, sel_ff};
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            guard_ff <= GUARD_KEY;
            trim_ff <= TRIM_RST;
            mon_en_ff <= 1'b1;
            sonet_ff <= sonet_sdh_sel_in;
            cfg_ff[0] <= {2'b00, strap_code(default_freq_straps_in)};
            cfg_ff[1] <= {2'b00, strap_code(default_freq_straps_in)};
            ref_divider_value_ff <= 16'h0000;
            edge_sel_ff <= 1'b0;
            irq_en_ff <= 2'b00;
            latched_ff <= 2'b00;
            reg_rdata_out <= 8'h00;
            valid_irq_out <= 1'b0;
        end else begin
            guard_ff <= nxt_guard;
            trim_ff <= nxt_trim;
            mon_en_ff <= nxt_mon_en;
            sonet_ff <= nxt_sonet;
            cfg_ff <= nxt_cfg;
            ref_divider_value_ff <= nxt_ref_divider_value;
            edge_sel_ff <= nxt_edge_sel;
            irq_en_ff <= nxt_irq_en;
            latched_ff <= nxt_latched;
            reg_rdata_out <= nxt_rdata;
            valid_irq_out <= nxt_irq;
        end
    end
    assign irq_ff = valid_irq_out;

    // --------------------------------------------------------------
    // master timebase
    // --------------------------------------------------------------
    // counts 204.8 MHz periods: 16 per oscillator edge, the fraction
    // carried by the trim; no fast clock is needed to measure against it
    logic osc_s_ff, osc_p_ff;
    logic [21:0] frac_ff, nxt_frac;
    logic [4:0] step, nxt_step;
    logic signed [23:0] frac_sum;

    always_comb begin
        frac_sum = $signed({2'b00, frac_ff}) + $signed(24'({1'b0, trim_ff}))
                   - $signed({7'h00, TRIM_ZERO});
        nxt_frac = frac_ff;
        step = 5'h00;
        if (osc_s_ff && !osc_p_ff) begin
            step = MASTER_PER_OSC;
            if (frac_sum < 0) begin
                nxt_frac = 22'(frac_sum + $signed({2'b00, TRIM_MOD}));
                step = MASTER_PER_OSC - 5'h01;
            end else if (frac_sum >= $signed({2'b00, TRIM_MOD})) begin
                nxt_frac = 22'(frac_sum - $signed({2'b00, TRIM_MOD}));
                step = MASTER_PER_OSC + 5'h01;
            end else begin
                nxt_frac = 22'(frac_sum);
            end
        end
        nxt_step = step;
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            osc_s_ff <= 1'b0;
            osc_p_ff <= 1'b0;
            frac_ff <= 22'h000000;
            master_step_out <= 5'h00;
        end else begin
            osc_s_ff <= local_osc_in;
            osc_p_ff <= osc_s_ff;
            frac_ff <= nxt_frac;
            master_step_out <= nxt_step;
        end
    end

    // --------------------------------------------------------------
    // lock dividers and frequency monitor
    // --------------------------------------------------------------
    logic [1:0] ref_s_ff, ref_p_ff, fail_ff, nxt_fail, nxt_evt;
    logic [1:0][15:0] divc_ff, nxt_divc;
    logic [1:0][23:0] meas_ff, nxt_meas;
    logic [1:0][5:0] wcnt_ff, nxt_wcnt;
    logic [1:0][23:0] expect_t, tol_t;
    logic [1:0] edge_t;

    always_comb begin
        nxt_divc = divc_ff;
        nxt_meas = meas_ff;
        nxt_wcnt = wcnt_ff;
        nxt_fail = fail_ff;
        nxt_evt = 2'b00;
        for (int i = 0; i < 2; i++) begin
            edge_t[i] = ref_s_ff[i] && !ref_p_ff[i];
            if (edge_sel_ff && eff_mode(cfg_ff[i]) == LM_EIGHT_K) begin
                edge_t[i] = !ref_s_ff[i] && ref_p_ff[i];
            end
            if (edge_t[i]) begin
                if (divc_ff[i] >= term_cnt(cfg_ff[i], sonet_ff, ref_divider_value_ff)) begin
                    nxt_divc[i] = 16'h0000;
                    nxt_evt[i] = 1'b1;
                end else begin
                    nxt_divc[i] = divc_ff[i] + 16'h0001;
                end
            end
            expect_t[i] = MEAS_SCALE / 24'(cmp_khz(cfg_ff[i], sonet_ff));
            tol_t[i] = 24'(({8'h00, expect_t[i]} * {24'h000000, TOL_MUL}) >> TOL_SHIFT);
            nxt_meas[i] = meas_ff[i] + 24'(step);
            if (meas_ff[i] > expect_t[i] + tol_t[i]) begin
                nxt_fail[i] = 1'b1;
                nxt_meas[i] = 24'h000000;
                nxt_wcnt[i] = 6'h00;
            end else if (nxt_evt[i]) begin
                nxt_wcnt[i] = wcnt_ff[i] + 6'h01;
                if (wcnt_ff[i] == MON_LAST) begin
                    nxt_fail[i] = meas_ff[i] < expect_t[i] - tol_t[i];
                    nxt_meas[i] = 24'h000000;
                end
            end
        end
        nxt_valid = ~((fail_ff & {2{mon_en_ff}}) | activity_alarm_in);
        nxt_sel = sel_ff;
        if (!nxt_valid[sel_ff] && nxt_valid[!sel_ff]) begin
            nxt_sel = !sel_ff;
        end
        nxt_sel_ok = nxt_valid[nxt_sel];
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            ref_s_ff <= 2'b00;
            ref_p_ff <= 2'b00;
            divc_ff <= '0;
            meas_ff <= '0;
            wcnt_ff <= '0;
            fail_ff <= 2'b11;
            valid_ff <= 2'b00;
            sel_ff <= 1'b0;
            sel_ok_ff <= 1'b0;
            lock_event_out <= 2'b00;
        end else begin
            ref_s_ff <= {ref_input_b_in, ref_input_a_in};
            ref_p_ff <= ref_s_ff;
            divc_ff <= nxt_divc;
            meas_ff <= nxt_meas;
            wcnt_ff <= nxt_wcnt;
            fail_ff <= nxt_fail;
            valid_ff <= nxt_valid;
            sel_ff <= nxt_sel;
            sel_ok_ff <= nxt_sel_ok;
            lock_event_out <= nxt_evt;
        end
    end
    assign input_valid_out = valid_ff;
    assign selected_ref_out = sel_ff;
    assign selected_ok_out = sel_ok_ff;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    property p_guard_hold;
        @(posedge mclk_in) disable iff (rst_in)
        (reg_wr_in && reg_addr_in == A_TRIM_LO && !guard_open) |=> $stable(trim_ff);
    endproperty
    a_guard_hold: assert property (p_guard_hold) else $error("guarded write landed");
    property p_ident;
        @(posedge mclk_in) disable iff (rst_in)
        (reg_rd_in && reg_addr_in == A_IDENT_HIGH) |=> reg_rdata_out == IDENT_CODE[15:8];
    endproperty
    a_ident: assert property (p_ident) else $error("identity read wrong");
    property p_latch;
        @(posedge mclk_in) disable iff (rst_in)
        (nxt_valid[0] != valid_ff[0]) |=> latched_ff[0];
    endproperty
    a_latch: assert property (p_latch) else $error("change not latched");
    property p_irq;
        @(posedge mclk_in) disable iff (rst_in)
        |(latched_ff & irq_en_ff) |=> irq_ff;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt missing");
    property p_act;
        @(posedge mclk_in) disable iff (rst_in)
        activity_alarm_in[1] |=> !input_valid_out[1];
    endproperty
    a_act: assert property (p_act) else $error("alarmed input valid");
    property p_sel;
        @(posedge mclk_in) disable iff (rst_in)
        selected_ok_out |-> input_valid_out[selected_ref_out];
    endproperty
    a_sel: assert property (p_sel) else $error("invalid input selected");
    property p_direct;
        @(posedge mclk_in) disable iff (rst_in)
        (eff_mode(cfg_ff[0]) == LM_DIRECT && ref_s_ff[0] && !ref_p_ff[0])
            |=> lock_event_out[0];
    endproperty
    a_direct: assert property (p_direct) else $error("direct edge lost");
    property p_low_rate;
        @(posedge mclk_in) disable iff (rst_in)
        (cfg_ff[1][FREQ_MSB:0] <= FC_4K && !cfg_ff[1][DIVMODE_BIT]
            && ref_s_ff[1] && !ref_p_ff[1]) |=> lock_event_out[1];
    endproperty
    a_low_rate: assert property (p_low_rate) else $error("low rate not direct");
    property p_mon_off;
        @(posedge mclk_in) disable iff (rst_in)
        (!mon_en_ff && !activity_alarm_in[0]) |=> input_valid_out[0];
    endproperty
    a_mon_off: assert property (p_mon_off) else $error("monitor off yet invalid");
endmodule // ref_input_config_monitor
`default_nettype wire

//--- testbench/ref_src_model.sv
// Purpose: local oscillator and two reference clock sources
// Assumes: all edges slower than mclk_in/2
// Notes:   references stand low while run_in is low
`timescale 1ns/1ps
`default_nettype none
module ref_src_model (
    input wire logic mclk_in,
    input wire logic run_in,
    input wire logic [7:0] half_in,
    output logic osc_out,
    output logic ref_a_out,
    output logic ref_b_out
);
    logic [1:0] osc_cnt;
    logic [7:0] ref_cnt;
    initial begin
        osc_cnt = 2'h0;
        ref_cnt = 8'h00;
        osc_out = 1'b0;
        ref_a_out = 1'b0;
        ref_b_out = 1'b0;
    end
    // oscillator runs free, period 4 master cycles
    always @(posedge mclk_in) begin
        osc_cnt <= osc_cnt + 2'h1;
        osc_out <= osc_cnt[1];
    end
    // edges at least half_in cycles apart keep the sampler happy
    always @(posedge mclk_in) begin
        if (!run_in) begin
            ref_cnt <= 8'h00;
            ref_a_out <= 1'b0;
            ref_b_out <= 1'b0;
        end else if (ref_cnt >= half_in - 8'h01) begin
            ref_cnt <= 8'h00;
            ref_a_out <= !ref_a_out;
            ref_b_out <= !ref_b_out;
        end else begin
            ref_cnt <= ref_cnt + 8'h01;
        end
    end
endmodule // ref_src_model
`default_nettype wire

//--- testbench/tb_ref_input_config_monitor.sv
// Purpose: self-checking bench for the reference input front end
// Assumes: straps sonet=1, freq=001 at first reset, 0 and 111 at the second
// Notes:   lock event counts allow one event of divider phase slack
`timescale 1ns/1ps
`default_nettype none
module tb_ref_input_config_monitor;
    import ref_cfg_pkg::*;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] reg_addr_in = 8'h00;
    logic [7:0] reg_wdata_in = 8'h00;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [7:0] reg_rdata_out;
    logic osc, ref_a, ref_b, run = 1'b0;
    logic [1:0] activity_alarm_in = 2'b00;
    logic [1:0] input_valid_out, lock_event_out;
    logic valid_irq_out, selected_ref_out, selected_ok_out;
    logic [4:0] master_step_out;
    int err_total = 0;
    int samples_checked = 0;
    int n;
    int n_b;
    logic sonet_strap = 1'b1;
    logic [2:0] freq_straps = 3'b001;
    logic [7:0] cfgs [5] = '{8'h03, 8'h20, 8'h3b, 8'h10, 8'h13};
    int ratios [5] = '{1, 3, 2, 1, 193};
    always #25 mclk_in = !mclk_in;
    ref_src_model src_u (.mclk_in(mclk_in), .run_in(run), .half_in(8'h04),
        .osc_out(osc), .ref_a_out(ref_a), .ref_b_out(ref_b));
    ref_input_config_monitor dut_u (.mclk_in(mclk_in), .rst_in(rst_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .local_osc_in(osc),
        .ref_input_a_in(ref_a), .ref_input_b_in(ref_b), .sonet_sdh_sel_in(sonet_strap),
        .default_freq_straps_in(freq_straps), .activity_alarm_in(activity_alarm_in),
        .input_valid_out(input_valid_out), .valid_irq_out(valid_irq_out),
        .lock_event_out(lock_event_out), .selected_ref_out(selected_ref_out),
        .selected_ok_out(selected_ok_out), .master_step_out(master_step_out));
    // --------------------------------------------------------------
    // access and compare tasks
    // --------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge mclk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge mclk_in);
        reg_rd_in <= 1'b0;
        #1;
        chk(reg_rdata_out, exp);
    endtask
    task automatic settle(input int c);
        repeat (c) @(posedge mclk_in);
        #1;
    endtask
    task automatic conclude;
        $display("checked=%0d errors=%0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #2000000;
        err_total++;
        conclude();
    end
    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        repeat (8) @(posedge mclk_in);
        rst_in <= 1'b0;
        rd(A_IDENT_LOW, IDENT_CODE[7:0]);
        wr(A_IDENT_HIGH, 8'h00);
        rd(A_IDENT_HIGH, IDENT_CODE[15:8]);
        rd(A_REVISION, REVISION_VAL);
        rd(8'h20, 8'h00);
        rd(A_MASTER_CFG3, 8'h01);
        rd(A_INPUT_CFG_A, 8'h03);
        rd(A_TRIM_LO, TRIM_RST[7:0]);
        $display("test ident and straps done");
        wr(A_WRITE_GUARD, 8'h00);
        wr(A_TRIM_LO, 8'h12);
        rd(A_TRIM_LO, TRIM_RST[7:0]);
        wr(A_WRITE_GUARD, GUARD_KEY);
        wr(A_TRIM_LO, 8'h12);
        rd(A_TRIM_LO, 8'h12);
        $display("test write guard done");
        wr(A_DIVIDER_LO, 8'h02);
        wr(A_DIVIDER_HI, 8'h00);
        wr(A_TEST_CFG1, 8'h01);
        run <= 1'b1;
        rd(A_TEST_CFG1, 8'h01);
        for (int m = 0; m < 5; m++) begin
            wr(A_INPUT_CFG_A, cfgs[m]);
            wr(A_INPUT_CFG_B, cfgs[m]);
            rd(A_INPUT_CFG_A, cfgs[m]);
            settle(32);
            n = 0;
            n_b = 0;
            for (int c = 0; c < 96 * ratios[m]; c++) begin
                settle(1);
                if (lock_event_out[0] === 1'b1)
                    n++;
                if (lock_event_out[1] === 1'b1)
                    n_b++;
            end
            samples_checked++;
            if (n < 11 || n > 13) begin
                err_total++;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, n, 12);
            end
            samples_checked++;
            if (n_b < 11 || n_b > 13) begin
                err_total++;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, n_b, 12);
            end
        end
        // references run far off nominal against the master timebase
        chk({6'h00, input_valid_out}, 8'h00);
        @(posedge mclk_in);
        run <= 1'b0;
        $display("test lock modes done");
        activity_alarm_in <= 2'b10;
        wr(A_VALID_LATCHED, 8'hff);
        wr(A_MASTER_CFG1, 8'h00);
        settle(4);
        chk({6'h00, input_valid_out}, 8'h01);
        rd(A_VALID_LIVE, 8'h01);
        rd(A_VALID_LATCHED, 8'h01);
        wr(A_VALID_IRQ_EN, 8'h01);
        settle(2);
        chk({7'h00, valid_irq_out}, 8'h01);
        wr(A_VALID_LATCHED, 8'h01);
        settle(2);
        chk({7'h00, valid_irq_out}, 8'h00);
        @(posedge mclk_in);
        activity_alarm_in <= 2'b00;
        settle(4);
        chk({6'h00, input_valid_out}, 8'h03);
        rd(A_VALID_LATCHED, 8'h02);
        chk({7'h00, valid_irq_out}, 8'h00);
        rd(A_SELECT_STAT, 8'h02);
        $display("test validity done");
        @(posedge mclk_in);
        rst_in <= 1'b1;
        sonet_strap <= 1'b0;
        freq_straps <= 3'b111;
        repeat (2) @(posedge mclk_in);
        rst_in <= 1'b0;
        rd(A_MASTER_CFG3, 8'h00);
        rd(A_INPUT_CFG_B, 8'h0a);
        $display("test strap reload done");
        conclude();
    end
endmodule // tb_ref_input_config_monitor
`default_nettype wire
